// ===== hdl/ppo_port.sv
`timescale 1ns/1ps
`default_nettype none

module ppo_port
  import ppo_pkg::*;
(
  input  wire logic              mclk_i,
  input  wire logic              rst_i,
  // Shared port strobes and data
  input  wire logic              dir_wr_i,
  input  wire logic              latch_wr_i,
  input  wire logic              pin_wr_i,
  input  wire logic [PORT_W-1:0] wdata_i,
  output logic      [PORT_W-1:0] dir_bit_o,
  output logic      [PORT_W-1:0] out_latch_bit_o,
  output logic      [PORT_W-1:0] pin_read_bit_o,
  // Global controls
  input  wire logic              global_pullup_disable_i,
  input  wire logic              sleep_i,
  // Peripheral overrides
  input  wire logic [PORT_W-1:0] pullup_override_en_i,
  input  wire logic [PORT_W-1:0] pullup_override_val_i,
  input  wire logic [PORT_W-1:0] dir_override_en_i,
  input  wire logic [PORT_W-1:0] dir_override_val_i,
  input  wire logic [PORT_W-1:0] outval_override_en_i,
  input  wire logic [PORT_W-1:0] outval_override_val_i,
  input  wire logic [PORT_W-1:0] latch_toggle_override_en_i,
  input  wire logic [PORT_W-1:0] input_enable_override_en_i,
  input  wire logic [PORT_W-1:0] input_enable_override_val_i,
  // Serial interface mode and data
  input  wire logic              ser_three_wire_i,
  input  wire logic              ser_data_out_i,
  // Pad side
  input  wire logic [PORT_W-1:0] pad_in_i,
  output logic      [PORT_W-1:0] pad_out_o,
  output logic      [PORT_W-1:0] pad_oe_o,
  output logic      [PORT_W-1:0] pad_pullup_o,
  output logic      [PORT_W-1:0] pad_input_en_o,
  // Alternate function taps
  output logic      [PORT_W-1:0] alt_raw_input_o,
  output logic      [PORT_W-1:0] analog_pad_line_o,
  output logic      [PORT_W-1:0] pin_change_source_o,
  output logic                   ext_irq_one_input_o,
  output logic                   serial_if_clock_3w_o,
  output logic                   serial_if_clock_2w_o,
  output logic                   serial_data_in_3w_o,
  output logic                   serial_data_line_2w_o,
  output logic                   timer0_capture_input_o,
  output logic                   analog_ch3_o
);

  // ------------------------------------------------------------------
  // Per-pin control bits
  // ------------------------------------------------------------------
  logic [PORT_W-1:0] dir_q;
  logic [PORT_W-1:0] latch_q;
  logic [PORT_W-1:0] latch_d;
  logic [PORT_W-1:0] pin_read_q;
  logic [PORT_W-1:0] raw_in;
  logic [PORT_W-1:0] pv_en_eff;
  logic [PORT_W-1:0] pv_val_eff;
  logic [PORT_W-1:0] cell_oe;
  logic [PORT_W-1:0] cell_out;
  logic [PORT_W-1:0] cell_pu;
  logic [PORT_W-1:0] cell_ie;

  // One write strobe serves every bit of the port
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      dir_q <= DIR_RST;
    end else if (dir_wr_i) begin
      dir_q <= wdata_i;
    end
  end

  // Software write lands first, then both toggle sources act on it, so
  // a toggle that coincides with a write is never lost.
  always_comb begin
    latch_d = latch_wr_i ? wdata_i : latch_q;
    if (pin_wr_i) begin
      latch_d = latch_d ^ wdata_i;
    end
    latch_d = latch_d ^ latch_toggle_override_en_i;
  end

  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      latch_q <= LATCH_RST;
    end else begin
      latch_q <= latch_d;
    end
  end

  // ------------------------------------------------------------------
  // Serial data output takes pin 1 in three-wire mode
  // ------------------------------------------------------------------
  always_comb begin
    pv_en_eff  = outval_override_en_i;
    pv_val_eff = outval_override_val_i;
    if (ser_three_wire_i) begin
      pv_en_eff[PIN_SER_DO]  = 1'b1;
      pv_val_eff[PIN_SER_DO] = ser_data_out_i;
    end
  end

  // ------------------------------------------------------------------
  // Pin cells
  // ------------------------------------------------------------------
  // Overrides arrive ready-made from the owning peripherals, except the pin 1 value override merged above in three-wire mode
  for (genvar n = 0; n < PORT_W; n++) begin : g_pin
    ppo_pin_cell u_cell (
      .dir_i    (dir_q[n]),
      .latch_i  (latch_q[n]),
      .no_pu_i  (global_pullup_disable_i),
      .sleep_i  (sleep_i),
      .pad_in_i (pad_in_i[n]),
      .pu_en_i  (pullup_override_en_i[n]),
      .pu_val_i (pullup_override_val_i[n]),
      .dd_en_i  (dir_override_en_i[n]),
      .dd_val_i (dir_override_val_i[n]),
      .pv_en_i  (pv_en_eff[n]),
      .pv_val_i (pv_val_eff[n]),
      .ie_en_i  (input_enable_override_en_i[n]),
      .ie_val_i (input_enable_override_val_i[n]),
      .pullup_o (cell_pu[n]),
      .oe_o     (cell_oe[n]),
      .out_o    (cell_out[n]),
      .ie_o     (cell_ie[n]),
      .raw_o    (raw_in[n])
    );
  end

  // ------------------------------------------------------------------
  // Read path synchroniser
  // ------------------------------------------------------------------
  ppo_sync #(
    .W (PORT_W)
  ) u_sync (
    .mclk_i  (mclk_i),
    .rst_i   (rst_i),
    .async_i (raw_in),
    .sync_o  (pin_read_q)
  );

  // ------------------------------------------------------------------
  // Outputs
  // ------------------------------------------------------------------
  // Reset gates the drivers and pull-ups directly so the pads float even
  // when no clock runs; the cost is a combinational path from rst_i.
  assign pad_oe_o       = cell_oe & {PORT_W{~rst_i}};
  assign pad_pullup_o   = cell_pu & {PORT_W{~rst_i}};
  assign pad_out_o      = cell_out;
  assign pad_input_en_o = cell_ie;

  assign dir_bit_o       = dir_q;
  assign out_latch_bit_o = latch_q;
  assign pin_read_bit_o  = pin_read_q;

  // Raw tap: receivers must synchronise it unless used as a clock
  assign alt_raw_input_o = raw_in;
  // Digital stand-in for the pad's analog node, ungated
  assign analog_pad_line_o = pad_in_i;

  assign pin_change_source_o    = raw_in;
  assign ext_irq_one_input_o    = raw_in[PIN_SER_CLK];
  assign serial_if_clock_3w_o   = raw_in[PIN_SER_CLK];
  assign serial_if_clock_2w_o   = raw_in[PIN_SER_CLK];
  assign serial_data_in_3w_o    = raw_in[PIN_SER_DATA];
  assign serial_data_line_2w_o  = raw_in[PIN_SER_DATA];
  assign timer0_capture_input_o = raw_in[PIN_CAPTURE];
  assign analog_ch3_o           = pad_in_i[PIN_CAPTURE];

  // ------------------------------------------------------------------
  // Assertions
  // ------------------------------------------------------------------
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (rst_i);

  sequence s_quiet_latch;
    !latch_wr_i && !pin_wr_i;
  endsequence

  sequence s_read_two;
    ##2 pin_read_q == $past(raw_in, SYNC_STAGES);
  endsequence

  pullup_normal_a: assert property (
    ((pad_pullup_o & ~pullup_override_en_i) ==
     (~dir_q & latch_q & {PORT_W{~global_pullup_disable_i}}
      & ~pullup_override_en_i)))
    else $error("pull-up wrong without override");

  pullup_ovr_a: assert property (
    ((pad_pullup_o & pullup_override_en_i) ==
     (pullup_override_val_i & pullup_override_en_i)))
    else $error("pull-up ignores override value");

  drive_normal_a: assert property (
    ((pad_oe_o & ~dir_override_en_i) == (dir_q & ~dir_override_en_i)))
    else $error("driver enable does not follow direction bit");

  drive_ovr_a: assert property (
    ((pad_oe_o & dir_override_en_i) ==
     (dir_override_val_i & dir_override_en_i)))
    else $error("driver enable ignores override value");

  value_ovr_a: assert property (
    ((pad_out_o & pv_en_eff) == (pv_val_eff & pv_en_eff)))
    else $error("pin level ignores value override");

  value_normal_a: assert property (
    ((pad_out_o & ~pv_en_eff) == (latch_q & ~pv_en_eff)))
    else $error("pin level differs from latch");

  toggle_latch_a: assert property (
    s_quiet_latch |=> latch_q ==
      ($past(latch_q) ^ $past(latch_toggle_override_en_i)))
    else $error("toggle override did not invert latch");

  pin_toggle_a: assert property (
    !latch_wr_i && pin_wr_i |=> latch_q ==
      ($past(latch_q) ^ $past(wdata_i)
       ^ $past(latch_toggle_override_en_i)))
    else $error("pin write did not toggle latch");

  input_en_a: assert property (
    ((pad_input_en_o & ~input_enable_override_en_i) ==
     ({PORT_W{~sleep_i}} & ~input_enable_override_en_i)))
    else $error("input enable does not follow sleep state");

  input_ovr_a: assert property (
    ((pad_input_en_o & input_enable_override_en_i) ==
     (input_enable_override_val_i & input_enable_override_en_i)))
    else $error("input enable ignores override value");

  raw_tap_a: assert property (
    alt_raw_input_o == (pad_in_i & pad_input_en_o))
    else $error("raw input not taken after clamp");

  read_sync_a: assert property (
    1'b1 |-> s_read_two)
    else $error("read path is not two stages deep");

  ser_do_a: assert property (
    ser_three_wire_i |-> pad_out_o[PIN_SER_DO] == ser_data_out_i)
    else $error("serial data out missing on pin 1");

  alt_map_a: assert property (
    ext_irq_one_input_o == alt_raw_input_o[PIN_SER_CLK] &&
    timer0_capture_input_o == alt_raw_input_o[PIN_CAPTURE])
    else $error("alternate pin map broken");

  ser_clk_map_a: assert property (
    serial_if_clock_3w_o == alt_raw_input_o[PIN_SER_CLK] &&
    serial_if_clock_2w_o == alt_raw_input_o[PIN_SER_CLK])
    else $error("serial clock not taken from pin 2");

  ser_in_map_a: assert property (
    serial_data_in_3w_o == alt_raw_input_o[PIN_SER_DATA] &&
    serial_data_line_2w_o == alt_raw_input_o[PIN_SER_DATA])
    else $error("serial data input not taken from pin 0");

  pin_change_a: assert property (
    pin_change_source_o == alt_raw_input_o)
    else $error("pin change sources not one per bit");

  analog_line_a: assert property (
    analog_pad_line_o == pad_in_i &&
    analog_ch3_o == pad_in_i[PIN_CAPTURE])
    else $error("analog line not tied to the pad");

  dir_load_a: assert property (
    dir_wr_i |=> dir_bit_o == $past(wdata_i))
    else $error("direction write did not land");

  dir_hold_a: assert property (
    !dir_wr_i |=> $stable(dir_bit_o))
    else $error("direction bits moved without a write");

  latch_load_a: assert property (
    latch_wr_i && !pin_wr_i |=> out_latch_bit_o ==
      ($past(wdata_i) ^ $past(latch_toggle_override_en_i)))
    else $error("latch write did not land");

endmodule : ppo_port

`default_nettype wire

// ===== hdl/ppo_pkg.sv
package ppo_pkg;

  // ------------------------------------------------------------------
  // Port geometry
  // ------------------------------------------------------------------
  localparam int unsigned PORT_W = 8;

  // ------------------------------------------------------------------
  // Reset values of the per-pin control bits
  // ------------------------------------------------------------------
  localparam logic [PORT_W-1:0] DIR_RST   = 8'h00;
  localparam logic [PORT_W-1:0] LATCH_RST = 8'h00;
  localparam logic [PORT_W-1:0] READ_RST  = 8'h00;

  // ------------------------------------------------------------------
  // Alternate function pin positions on the first port
  // ------------------------------------------------------------------
  localparam int unsigned PIN_SER_DATA = 0;
  localparam int unsigned PIN_SER_DO   = 1;
  localparam int unsigned PIN_SER_CLK  = 2;
  localparam int unsigned PIN_CAPTURE  = 4;

  // ------------------------------------------------------------------
  // Read synchroniser depth
  // ------------------------------------------------------------------
  localparam int unsigned SYNC_STAGES = 2;

endpackage : ppo_pkg

// ===== hdl/ppo_sync.sv
`timescale 1ns/1ps
`default_nettype none

module ppo_sync
  import ppo_pkg::*;
#(
  parameter int unsigned W = PORT_W
) (
  input  wire logic         mclk_i,
  input  wire logic         rst_i,
  input  wire logic [W-1:0] async_i,
  output logic      [W-1:0] sync_o
);

  logic [W-1:0] meta_q;
  logic [W-1:0] sync_q;

  // First stage is read only by the second one
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      meta_q <= READ_RST;
      sync_q <= READ_RST;
    end else begin
      meta_q <= async_i;
      sync_q <= meta_q;
    end
  end

  assign sync_o = sync_q;

endmodule : ppo_sync

`default_nettype wire

// ===== hdl/ppo_pin_cell.sv
`timescale 1ns/1ps
`default_nettype none

module ppo_pin_cell (
  input  wire logic dir_i,
  input  wire logic latch_i,
  input  wire logic no_pu_i,
  input  wire logic sleep_i,
  input  wire logic pad_in_i,
  input  wire logic pu_en_i,
  input  wire logic pu_val_i,
  input  wire logic dd_en_i,
  input  wire logic dd_val_i,
  input  wire logic pv_en_i,
  input  wire logic pv_val_i,
  input  wire logic ie_en_i,
  input  wire logic ie_val_i,
  output logic      pullup_o,
  output logic      oe_o,
  output logic      out_o,
  output logic      ie_o,
  output logic      raw_o
);

  // Pure combinational mux: an override reaches the pad in its own cycle
  always_comb begin
    pullup_o = pu_en_i ? pu_val_i : (~dir_i & latch_i & ~no_pu_i);
    oe_o     = dd_en_i ? dd_val_i : dir_i;
    out_o    = pv_en_i ? pv_val_i : latch_i;
    ie_o     = ie_en_i ? ie_val_i : ~sleep_i;
    // Clamp ahead of the Schmitt output; no synchroniser on this path
    raw_o    = pad_in_i & ie_o;
  end

endmodule : ppo_pin_cell

`default_nettype wire

// ===== tb/ppo_periph_model.sv
`timescale 1ns/1ps
`default_nettype none

module ppo_periph_model
  import ppo_pkg::*;
(
  input  wire logic              mclk_i,
  input  wire logic              rst_i,
  input  wire logic [PORT_W-1:0] raw_i,
  output logic      [PORT_W-1:0] pue_o,
  output logic      [PORT_W-1:0] puv_o,
  output logic      [PORT_W-1:0] dde_o,
  output logic      [PORT_W-1:0] ddv_o,
  output logic      [PORT_W-1:0] pve_o,
  output logic      [PORT_W-1:0] pvv_o,
  output logic      [PORT_W-1:0] iee_o,
  output logic      [PORT_W-1:0] iev_o,
  output logic      [PORT_W-1:0] tog_o,
  output logic      [PORT_W-1:0] sync_o
);
  logic [PORT_W-1:0] meta_q;

  // Overrides are plain levels owned by the peripheral
  task automatic set_ovr(input logic [8*PORT_W-1:0] v);
    {pue_o, puv_o, dde_o, ddv_o, pve_o, pvv_o, iee_o, iev_o} = v;
  endtask : set_ovr

  // One cycle only: a held toggle would invert the latch every cycle
  task automatic pulse_tog(input logic [PORT_W-1:0] m);
    tog_o = m;
    @(posedge mclk_i);
    #1;
    tog_o = '0;
  endtask : pulse_tog

  initial begin
    set_ovr('0);
    tog_o = '0;
  end

  // The raw tap is asynchronous, so resynchronise before use
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      meta_q <= '0;
      sync_o <= '0;
    end else begin
      meta_q <= raw_i;
      sync_o <= meta_q;
    end
  end
endmodule : ppo_periph_model

`default_nettype wire

// ===== tb/tb.sv
`timescale 1ns/1ps
`default_nettype none

`define CHK(got, exp) begin tests_run++; if ((got) !== (exp)) begin \
  fails++; $display("MISMATCH t=%0t %h vs %h", $time, got, exp); end end

module tb
  import ppo_pkg::*;
();
  typedef logic [PORT_W-1:0] ppo_v_t;
  logic   mclk_i, rst_i, dw, lw, pw, pu_off, slp, tw, sdo;
  ppo_v_t wd, pad, dir_b, lat_b, rd_b, p_out, p_oe, p_pu, p_ie;
  ppo_v_t raw, ana, pcs, pue, puv, dde, ddv, pve, pvv, iee, iev, tog;
  ppo_v_t msync, e_dir, e_lat;
  logic   irq1, ck3, ck2, di3, sda2, icp, ach3;
  int     fails, tests_run;

  ppo_port dut (.mclk_i(mclk_i), .rst_i(rst_i), .dir_wr_i(dw),
    .latch_wr_i(lw), .pin_wr_i(pw), .wdata_i(wd), .dir_bit_o(dir_b),
    .out_latch_bit_o(lat_b), .pin_read_bit_o(rd_b),
    .global_pullup_disable_i(pu_off), .sleep_i(slp),
    .pullup_override_en_i(pue), .pullup_override_val_i(puv),
    .dir_override_en_i(dde), .dir_override_val_i(ddv),
    .outval_override_en_i(pve), .outval_override_val_i(pvv),
    .latch_toggle_override_en_i(tog), .input_enable_override_en_i(iee),
    .input_enable_override_val_i(iev), .ser_three_wire_i(tw),
    .ser_data_out_i(sdo), .pad_in_i(pad), .pad_out_o(p_out),
    .pad_oe_o(p_oe), .pad_pullup_o(p_pu), .pad_input_en_o(p_ie),
    .alt_raw_input_o(raw), .analog_pad_line_o(ana),
    .pin_change_source_o(pcs), .ext_irq_one_input_o(irq1),
    .serial_if_clock_3w_o(ck3), .serial_if_clock_2w_o(ck2),
    .serial_data_in_3w_o(di3), .serial_data_line_2w_o(sda2),
    .timer0_capture_input_o(icp), .analog_ch3_o(ach3));

  ppo_periph_model m (.mclk_i(mclk_i), .rst_i(rst_i), .raw_i(raw),
    .pue_o(pue), .puv_o(puv), .dde_o(dde), .ddv_o(ddv), .pve_o(pve),
    .pvv_o(pvv), .iee_o(iee), .iev_o(iev), .tog_o(tog), .sync_o(msync));

  // ---------------------------------------------------------------
  // Access tasks
  // ---------------------------------------------------------------
  task automatic step();
    @(posedge mclk_i);
    #1;
  endtask : step

  // Strobes stay up so back-to-back writes never double-assign
  task automatic wr(input logic d, l, p, input ppo_v_t v);
    dw = d;
    lw = l;
    pw = p;
    wd = v;
    step();
    if (d) e_dir = v;
    e_lat = (l ? v : e_lat) ^ (p ? v : 8'h00);
    `CHK(dir_b, e_dir)
    `CHK(lat_b, e_lat)
  endtask : wr

  task automatic idle();
    dw = 0;
    lw = 0;
    pw = 0;
    step();
  endtask : idle

  task automatic check_pins();
    ppo_v_t oe, pv, ie, rw;
    oe = (dde & ddv) | (~dde & e_dir);
    pv = (pve & pvv) | (~pve & e_lat);
    if (tw) pv[1] = sdo;
    ie = (iee & iev) | (~iee & {8{~slp}});
    rw = pad & ie;
    `CHK(p_oe, oe)
    `CHK(p_out & oe, pv & oe)
    `CHK(p_pu, (pue & puv) | (~pue & ~e_dir & e_lat & {8{~pu_off}}))
    `CHK(p_ie, ie)
    `CHK(raw, rw)
    `CHK(pcs, rw)
    `CHK({irq1, ck3, ck2}, {3{rw[2]}})
    `CHK({di3, sda2, icp}, {rw[0], rw[0], rw[4]})
    `CHK({ana, ach3}, {pad, pad[4]})
  endtask : check_pins

  task automatic end_of_test();
    $display("comparisons %0d mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : end_of_test

  // ---------------------------------------------------------------
  // Stimulus
  // ---------------------------------------------------------------
  initial begin
    mclk_i = 0;
    forever #2 mclk_i = ~mclk_i;
  end

  initial begin
    #20000;
    fails++;
    end_of_test();
  end

  logic [63:0] ovr_tab [4] = '{64'h0, 64'hffff_ffff_ffff_ffff,
    64'hff5a_ff0f_ffa5_ff3c, 64'h0fff_f0f0_33cc_55aa};

  initial begin
    {dw, lw, pw, pu_off, slp, tw, sdo} = '0;
    {wd, e_dir, e_lat} = '0;
    pad = 8'h69;
    fails = 0;
    tests_run = 0;
    rst_i = 1;
    #1;
    m.set_ovr(64'hffff_ffff_0000_0000);
    repeat (16) step();
    // Pads must float in reset even against overrides
    `CHK({p_oe, p_pu}, 16'h0000)
    `CHK({dir_b, lat_b, rd_b}, {DIR_RST, LATCH_RST, READ_RST})
    m.set_ovr('0);
    rst_i = 0;
    step();
    wr(1, 0, 0, 8'ha5);
    wr(0, 1, 0, 8'h3c);
    wr(0, 0, 1, 8'h0f);
    wr(1, 1, 1, 8'hc3);
    wr(0, 1, 0, 8'hf0);
    idle();
    for (int i = 0; i < 4; i++) begin
      pu_off = i[0];
      wr(1, 0, 0, i[1] ? 8'h55 : 8'h00);
      idle();
      check_pins();
    end
    for (int i = 0; i < 8; i++) begin
      slp = i[2];
      pad = 8'h96 ^ 8'(i);
      m.set_ovr(ovr_tab[i % 4]);
      step();
      check_pins();
    end
    m.set_ovr('0);
    wr(1, 0, 0, 8'hff);
    idle();
    for (int i = 0; i < 2; i++) begin
      tw = 1;
      sdo = i[0];
      step();
      check_pins();
    end
    tw = 0;
    m.pulse_tog(8'h81);
    e_lat ^= 8'h81;
    `CHK(lat_b, e_lat)
    slp = 0;
    pad = 8'h96;
    step();
    step();
    `CHK(rd_b, 8'h96)
    `CHK(msync, 8'h96)
    slp = 1;
    step();
    step();
    `CHK(rd_b, 8'h00)
    check_pins();
    // Mid-run reset must float the pads at once, clock edge or not
    rst_i = 1;
    #1;
    `CHK({p_oe, p_pu, dir_b, lat_b}, 32'h0000_0000)
    step();
    rst_i = 0;
    {e_dir, e_lat} = {DIR_RST, LATCH_RST};
    wr(0, 1, 0, 8'h5a);
    end_of_test();
  end
endmodule : tb

`default_nettype wire
